/* File: src/ccr_pkg.sv */
package ccr_pkg;

    // ****************
    // Register map
    // ****************
    localparam logic [7:0] CCR_ADDR_POWER1 = 8'h64;
    localparam logic [7:0] CCR_ADDR_POWER2 = 8'h65;
    localparam logic [7:0] CCR_ADDR_MODE = 8'h70;
    localparam logic [7:0] CCR_ADDR_SCRAM = 8'h71;
    localparam logic [7:0] CCR_ADDR_CLKDIV = 8'h72;

    localparam logic [15:0] CCR_RST_POWER1 = 16'h0000;
    localparam logic [15:0] CCR_RST_POWER2 = 16'h0000;
    localparam logic [15:0] CCR_RST_MODE = 16'h0000;
    localparam logic [15:0] CCR_RST_SCRAM = 16'h0000;
    localparam logic [15:0] CCR_RST_CLKDIV = 16'h0000;

    localparam logic [15:0] CCR_MASK_POWER = 16'h00ff;
    localparam logic [15:0] CCR_MASK_MODE = 16'h0007;
    localparam logic [15:0] CCR_MASK_SCRAM = 16'hb7ff;
    localparam logic [15:0] CCR_MASK_CLKDIV = 16'hffff;

    // ****************
    // Field positions
    // ****************
    localparam int CCR_P2_ANALOG_EN = 0;
    localparam int CCR_P2_OSC_SAVE = 1;
    localparam int CCR_SC_TX_EN = 15;
    localparam int CCR_SC_TX_INV = 13;
    localparam int CCR_SC_RX_EN = 12;
    localparam int CCR_SC_RX_INV = 10;
    localparam int CCR_CD_PRE_EN = 15;
    localparam int CCR_CD_DEC_EN = 14;
    localparam int CCR_CD_ENC_EN = 13;
    localparam int CCR_CD_FPRE_LSB = 11;
    localparam int CCR_CD_FDIV_LSB = 8;
    localparam int CCR_CD_BPRE_LSB = 6;
    localparam int CCR_CD_DDIV_LSB = 3;
    localparam int CCR_CD_EDIV_LSB = 0;

    // ****************
    // Codec modes
    // ****************
    localparam logic [2:0] CCR_MODE_ADM_UNBUF = 3'h0;
    localparam logic [2:0] CCR_MODE_ADM_BUF = 3'h1;
    localparam logic [2:0] CCR_MODE_PCM_LIN = 3'h2;
    localparam logic [2:0] CCR_MODE_PCM_MU = 3'h3;
    localparam logic [2:0] CCR_MODE_PCM_A = 3'h4;

    // ****************
    // Divider constants
    // ****************
    localparam logic [8:0] CCR_FILT_STEP = 9'h004;
    localparam logic [5:0] CCR_BIT_STEP = 6'h08;
    localparam logic [6:0] CCR_POST_DIV = 7'h40;
    localparam logic [6:0] CCR_PLL_STEP = 7'h02;
    localparam logic [1:0] CCR_PLL_HOLD = 2'h2;

    // Power field carrier, in register bit order
    typedef struct packed {
        logic [1:0] mic_amp;
        logic [1:0] digital_gain_amp;
        logic [1:0] volume_amp;
        logic [1:0] anti_alias_filter;
        logic [1:0] aif;
        logic [1:0] enc_dac;
        logic [1:0] dec_dac;
    } ccr_power_t;

    // Filter divide ratio in quarter steps
    function automatic logic [8:0] ccr_filt_ratio(input logic [2:0] code);
        case (code)
            3'h0: ccr_filt_ratio = 9'h008;
            3'h1: ccr_filt_ratio = 9'h020;
            3'h2: ccr_filt_ratio = 9'h03e;
            3'h3: ccr_filt_ratio = 9'h03f;
            3'h4: ccr_filt_ratio = 9'h040;
            3'h5: ccr_filt_ratio = 9'h058;
            3'h6: ccr_filt_ratio = 9'h07d;
            default: ccr_filt_ratio = 9'h0bb;
        endcase
    endfunction

    // Bit clock divide ratio in eighth steps
    function automatic logic [5:0] ccr_bit_ratio(input logic [2:0] code);
        case (code)
            3'h0: ccr_bit_ratio = 6'h08;
            3'h1: ccr_bit_ratio = 6'h10;
            3'h2: ccr_bit_ratio = 6'h12;
            3'h3: ccr_bit_ratio = 6'h15;
            3'h4: ccr_bit_ratio = 6'h18;
            3'h5: ccr_bit_ratio = 6'h19;
            3'h6: ccr_bit_ratio = 6'h1b;
            default: ccr_bit_ratio = 6'h1c;
        endcase
    endfunction

endpackage

/* File: src/ccr_codec_control.sv */
module ccr_codec_control
    import ccr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic pll_enable,
    input wire logic pll_phase_advance,
    input wire logic pll_phase_retard,
    input wire logic tx_bit_in,
    input wire logic tx_bit_valid,
    output logic tx_bit_out,
    output logic tx_bit_out_valid,
    input wire logic rx_bit_in,
    input wire logic rx_bit_valid,
    output logic rx_bit_out,
    output logic rx_bit_out_valid,
    output ccr_power_t power,
    output logic osc_power_down,
    output logic bandgap_enable,
    output logic [2:0] codec_mode,
    output logic codec_buffered_io,
    output logic codec_pcm,
    output logic sc_filter_tick,
    output logic enc_bit_clk_tick,
    output logic dec_bit_clk_tick
);

    // ****************
    // Register file
    // ****************
    logic [15:0] power1_r;
    logic [15:0] power2_r;
    logic [15:0] mode_r;
    logic [15:0] scram_r;
    logic [15:0] clkdiv_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            power1_r <= CCR_RST_POWER1;
            power2_r <= CCR_RST_POWER2;
            mode_r <= CCR_RST_MODE;
            scram_r <= CCR_RST_SCRAM;
            clkdiv_r <= CCR_RST_CLKDIV;
        end else if (reg_wr) begin
            case (reg_addr)
                CCR_ADDR_POWER1: power1_r <= reg_wdata & CCR_MASK_POWER;
                CCR_ADDR_POWER2: power2_r <= reg_wdata & CCR_MASK_POWER;
                CCR_ADDR_MODE: mode_r <= reg_wdata & CCR_MASK_MODE;
                CCR_ADDR_SCRAM: scram_r <= reg_wdata & CCR_MASK_SCRAM;
                CCR_ADDR_CLKDIV: clkdiv_r <= reg_wdata & CCR_MASK_CLKDIV;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                CCR_ADDR_POWER1: rdata_nxt = power1_r;
                CCR_ADDR_POWER2: rdata_nxt = power2_r;
                CCR_ADDR_MODE: rdata_nxt = mode_r;
                CCR_ADDR_SCRAM: rdata_nxt = scram_r;
                CCR_ADDR_CLKDIV: rdata_nxt = clkdiv_r;
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ****************
    // Power control
    // ****************
    ccr_power_t power_r;
    logic osc_down_r;
    logic bandgap_r;
    logic analog_en;

    assign analog_en = power2_r[CCR_P2_ANALOG_EN];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            power_r <= '0;
            osc_down_r <= 1'b0;
            bandgap_r <= 1'b0;
        end else begin
            if (analog_en) begin
                power_r <= ccr_power_t'({power2_r[7:2], power1_r[7:0]});
            end else begin
                power_r <= '0;
            end
            bandgap_r <= analog_en;
            osc_down_r <= power2_r[CCR_P2_OSC_SAVE];
        end
    end

    assign power = power_r;
    assign osc_power_down = osc_down_r;
    assign bandgap_enable = bandgap_r;

    // ****************
    // Codec mode
    // ****************
    logic [2:0] mode_out_r;
    logic buffered_r;
    logic pcm_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_out_r <= CCR_MODE_ADM_UNBUF;
            buffered_r <= 1'b0;
            pcm_r <= 1'b0;
        end else begin
            mode_out_r <= mode_r[2:0];
            case (mode_r[2:0])
                CCR_MODE_ADM_BUF: begin
                    buffered_r <= 1'b1;
                    pcm_r <= 1'b0;
                end
                CCR_MODE_PCM_LIN, CCR_MODE_PCM_MU, CCR_MODE_PCM_A: begin
                    buffered_r <= 1'b1;
                    pcm_r <= 1'b1;
                end
                default: begin
                    buffered_r <= 1'b0;
                    pcm_r <= 1'b0;
                end
            endcase
        end
    end

    assign codec_mode = mode_out_r;
    assign codec_buffered_io = buffered_r;
    assign codec_pcm = pcm_r;

    // ****************
    // Scrambler and de-scrambler
    // ****************
    logic [9:0] taps;
    logic [9:0] tx_state_r;
    logic [9:0] rx_state_r;
    logic tx_out_r;
    logic tx_out_valid_r;
    logic rx_out_r;
    logic rx_out_valid_r;
    logic tx_mix;
    logic rx_line;

    assign taps = scram_r[9:0];
    assign tx_mix = tx_bit_in ^ (scram_r[CCR_SC_TX_EN] & (^(taps & tx_state_r)));
    assign rx_line = rx_bit_in ^ scram_r[CCR_SC_RX_INV];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_state_r <= 10'h000;
            tx_out_r <= 1'b0;
            tx_out_valid_r <= 1'b0;
        end else begin
            tx_out_valid_r <= tx_bit_valid;
            if (tx_bit_valid) begin
                tx_out_r <= tx_mix ^ scram_r[CCR_SC_TX_INV];
                tx_state_r <= {tx_state_r[8:0], tx_mix};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx_state_r <= 10'h000;
            rx_out_r <= 1'b0;
            rx_out_valid_r <= 1'b0;
        end else begin
            rx_out_valid_r <= rx_bit_valid;
            if (rx_bit_valid) begin
                rx_out_r <= rx_line ^ (scram_r[CCR_SC_RX_EN] & (^(taps & rx_state_r)));
                rx_state_r <= {rx_state_r[8:0], rx_line};
            end
        end
    end

    assign tx_bit_out = tx_out_r;
    assign tx_bit_out_valid = tx_out_valid_r;
    assign rx_bit_out = rx_out_r;
    assign rx_bit_out_valid = rx_out_valid_r;

    // ****************
    // Prescalers: index 0 filter, index 1 bit clocks
    // ****************
    logic [1:0] pre_tick;
    logic [1:0] pre_code [2];

    assign pre_code[0] = clkdiv_r[CCR_CD_FPRE_LSB +: 2];
    assign pre_code[1] = clkdiv_r[CCR_CD_BPRE_LSB +: 2];

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_pre
            logic [1:0] cnt_r;
            always_ff @(posedge ref_clk) begin
                if (reset || !clkdiv_r[CCR_CD_PRE_EN]) begin
                    cnt_r <= 2'h0;
                end else if (cnt_r >= pre_code[gp]) begin
                    cnt_r <= 2'h0;
                end else begin
                    cnt_r <= cnt_r + 2'h1;
                end
            end
            assign pre_tick[gp] = !clkdiv_r[CCR_CD_PRE_EN] || (cnt_r >= pre_code[gp]);
        end
    endgenerate

    // ****************
    // Filter clock divider
    // ****************
    logic [8:0] filt_acc_r;
    logic [8:0] filt_sum;
    logic [8:0] filt_ratio;
    logic filt_tick_r;
    logic div_wr;

    assign div_wr = reg_wr && (reg_addr == CCR_ADDR_CLKDIV);
    assign filt_ratio = ccr_filt_ratio(clkdiv_r[CCR_CD_FDIV_LSB +: 3]);
    assign filt_sum = filt_acc_r + CCR_FILT_STEP;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            filt_acc_r <= 9'h000;
            filt_tick_r <= 1'b0;
        end else if (div_wr) begin
            // Clear the stale remainder so a smaller ratio gives no tick burst
            filt_acc_r <= 9'h000;
            filt_tick_r <= 1'b0;
        end else begin
            filt_tick_r <= 1'b0;
            if (pre_tick[0]) begin
                if (filt_sum >= filt_ratio) begin
                    filt_acc_r <= filt_sum - filt_ratio;
                    filt_tick_r <= 1'b1;
                end else begin
                    filt_acc_r <= filt_sum;
                end
            end
        end
    end

    assign sc_filter_tick = filt_tick_r;

    // ****************
    // Bit clock dividers: index 0 encode, index 1 decode
    // ****************
    logic [1:0] chan_en;
    logic [2:0] bit_code [2];
    logic [1:0] bit_tick;

    assign chan_en[0] = clkdiv_r[CCR_CD_ENC_EN];
    assign chan_en[1] = clkdiv_r[CCR_CD_DEC_EN];
    assign bit_code[0] = clkdiv_r[CCR_CD_EDIV_LSB +: 3];
    assign bit_code[1] = clkdiv_r[CCR_CD_DDIV_LSB +: 3];

    genvar gb;
    generate
        for (gb = 0; gb < 2; gb++) begin : g_bit
            logic [5:0] acc_r;
            logic [5:0] sum;
            logic [5:0] ratio;
            logic [5:0] post_r;
            logic [1:0] hold_r;
            logic [6:0] post_sum;
            logic frac_tick;
            logic adv;
            logic ret;
            logic tick_r;

            assign ratio = ccr_bit_ratio(bit_code[gb]);
            assign sum = acc_r + CCR_BIT_STEP;
            assign frac_tick = pre_tick[1] && (sum >= ratio);
            assign adv = (gb == 1) && pll_enable && pll_phase_advance;
            assign ret = (gb == 1) && pll_enable && pll_phase_retard;
            assign post_sum = {1'b0, post_r}
                + {6'h00, frac_tick && (hold_r == 2'h0)}
                + (adv ? CCR_PLL_STEP : 7'h00);

            always_ff @(posedge ref_clk) begin
                if (reset || !chan_en[gb]) begin
                    acc_r <= 6'h00;
                end else if (pre_tick[1]) begin
                    acc_r <= frac_tick ? sum - ratio : sum;
                end
            end

            always_ff @(posedge ref_clk) begin
                if (reset || !chan_en[gb]) begin
                    post_r <= 6'h00;
                    hold_r <= 2'h0;
                    tick_r <= 1'b0;
                end else begin
                    post_r <= post_sum[5:0];
                    tick_r <= post_sum >= CCR_POST_DIV;
                    if (ret) begin
                        hold_r <= CCR_PLL_HOLD;
                    end else if (frac_tick && hold_r != 2'h0) begin
                        hold_r <= hold_r - 2'h1;
                    end
                end
            end

            assign bit_tick[gb] = tick_r;
        end
    endgenerate

    assign enc_bit_clk_tick = bit_tick[0];
    assign dec_bit_clk_tick = bit_tick[1];

endmodule

/* File: tb/ccr_codec_control_monitor.sv */
module ccr_codec_control_monitor
    import ccr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic tx_bit_valid,
    input wire logic tx_bit_out_valid,
    input wire ccr_power_t power,
    input wire logic osc_power_down,
    input wire logic bandgap_enable,
    input wire logic [2:0] codec_mode,
    input wire logic codec_buffered_io,
    input wire logic codec_pcm,
    input wire logic enc_bit_clk_tick,
    input wire logic dec_bit_clk_tick
);
    logic p2_wr;
    logic [7:0] enc_gap_r;
    logic enc_seen_r;

    assign p2_wr = reg_wr && reg_addr == CCR_ADDR_POWER2;

    // ****************
    // Encode tick spacing
    // ****************
    always_ff @(posedge ref_clk) begin
        if (reset || enc_bit_clk_tick) begin
            enc_gap_r <= 8'h00;
        end else if (enc_gap_r != 8'hff) begin
            enc_gap_r <= enc_gap_r + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            enc_seen_r <= 1'b0;
        end else if (enc_bit_clk_tick) begin
            enc_seen_r <= 1'b1;
        end
    end

    // ****************
    // Checks
    // ****************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    chk_power_flags: assert property (
        p2_wr |-> ##2 {osc_power_down, bandgap_enable} == $past(reg_wdata[1:0], 2))
        else $error("power flags differ from write");
    chk_analog_gate: assert property (
        (p2_wr && !reg_wdata[0]) |-> ##2 power == '0)
        else $error("power fields not gated off");
    chk_volume_field: assert property (
        (p2_wr && reg_wdata[0]) |-> ##2 power.volume_amp == $past(reg_wdata[3:2], 2))
        else $error("volume power field wrong");
    chk_mode_write: assert property (
        (reg_wr && reg_addr == CCR_ADDR_MODE) |-> ##2 codec_mode == $past(reg_wdata[2:0], 2))
        else $error("codec mode differs from write");
    chk_mode_class: assert property (
        codec_pcm == (codec_mode inside {3'h2, 3'h3, 3'h4})
        && codec_buffered_io == (codec_mode inside {3'h1, 3'h2, 3'h3, 3'h4}))
        else $error("mode class flags wrong");
    chk_mode_rsvd: assert property (
        (reg_rd && reg_addr == CCR_ADDR_MODE) |=> reg_rdata[15:3] == 13'h0000)
        else $error("mode upper bits read nonzero");
    chk_scram_rsvd: assert property (
        (reg_rd && reg_addr == CCR_ADDR_SCRAM) |=> !reg_rdata[14] && !reg_rdata[11])
        else $error("scrambler spare bits read nonzero");
    chk_tx_answer: assert property (
        tx_bit_valid |=> tx_bit_out_valid)
        else $error("scrambler output valid missing");
    chk_dec_stop: assert property (
        (reg_wr && reg_addr == CCR_ADDR_CLKDIV && !reg_wdata[14])
        |-> ##4 (!dec_bit_clk_tick) [*8])
        else $error("decode tick while disabled");
    chk_enc_gap: assert property (
        (enc_seen_r && enc_bit_clk_tick) |-> enc_gap_r >= 8'd63)
        else $error("encode ticks closer than 64");
endmodule

bind ccr_codec_control ccr_codec_control_monitor u_monitor (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_bit_valid(tx_bit_valid),
    .tx_bit_out_valid(tx_bit_out_valid), .power(power), .osc_power_down(osc_power_down),
    .bandgap_enable(bandgap_enable), .codec_mode(codec_mode),
    .codec_buffered_io(codec_buffered_io), .codec_pcm(codec_pcm),
    .enc_bit_clk_tick(enc_bit_clk_tick), .dec_bit_clk_tick(dec_bit_clk_tick));

/* File: tb/ccr_codec_control_test.sv */
module ccr_codec_control_test
    import ccr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk, reset, reg_wr, reg_rd, tx_bit_in, tx_bit_valid, rx_bit_in, rx_bit_valid;
    logic pll_enable, pll_phase_advance, pll_phase_retard;
    logic tx_bit_out, tx_bit_out_valid, rx_bit_out, rx_bit_out_valid, osc_power_down;
    logic bandgap_enable, codec_buffered_io, codec_pcm;
    logic sc_filter_tick, enc_bit_clk_tick, dec_bit_clk_tick;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d, cfg;
    logic [2:0] codec_mode;
    ccr_power_t power;
    logic [9:0] ts, rs;
    logic m, l, eo, ro;
    int compares, miscompares;
    logic [39:0] rows [6] = '{{8'h70, 16'hffff, 16'h0007}, {8'h71, 16'hffff, 16'hb7ff},
        {8'h72, 16'ha5c3, 16'ha5c3}, {8'h65, 16'h12ff, 16'h00ff},
        {8'h64, 16'hff41, 16'h0041}, {8'h73, 16'h1234, 16'h0000}};
    // Divider setting, then encode, decode and filter tick periods
    logic [51:0] crow [8] = '{{16'h6000, 12'd64, 12'd64, 12'd2},
        {16'h6008, 12'd64, 12'd128, 12'd2}, {16'he040, 12'd128, 12'd128, 12'd2},
        {16'h2101, 12'd128, 12'd0, 12'd8}, {16'h6013, 12'd168, 12'd144, 12'd2},
        {16'h6425, 12'd200, 12'd192, 12'd16}, {16'h6537, 12'd224, 12'd216, 12'd22},
        {16'hd900, 12'd0, 12'd64, 12'd32}};
    // Divider setting, window in cycles and filter ticks expected in it
    logic [31:0] frow [4] = '{{16'h0200, 12'd31, 4'd2}, {16'h0300, 12'd63, 4'd4},
        {16'h0600, 12'd125, 4'd4}, {16'h9700, 12'd561, 4'd4}};
    logic [7:0] addrs [5] = '{8'h64, 8'h65, 8'h70, 8'h71, 8'h72};
    logic [15:0] pat = 16'hb38e;

    ccr_codec_control DUT (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pll_enable(pll_enable), .pll_phase_advance(pll_phase_advance),
        .pll_phase_retard(pll_phase_retard), .tx_bit_in(tx_bit_in),
        .tx_bit_valid(tx_bit_valid), .tx_bit_out(tx_bit_out),
        .tx_bit_out_valid(tx_bit_out_valid), .rx_bit_in(rx_bit_in),
        .rx_bit_valid(rx_bit_valid), .rx_bit_out(rx_bit_out),
        .rx_bit_out_valid(rx_bit_out_valid), .power(power), .osc_power_down(osc_power_down),
        .bandgap_enable(bandgap_enable), .codec_mode(codec_mode),
        .codec_buffered_io(codec_buffered_io), .codec_pcm(codec_pcm),
        .sc_filter_tick(sc_filter_tick), .enc_bit_clk_tick(enc_bit_clk_tick),
        .dec_bit_clk_tick(dec_bit_clk_tick));

    // ****************
    // Helpers
    // ****************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Called just after a clock edge
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic settle;
        @(posedge ref_clk);
        #1;
    endtask

    function automatic logic tick(input int s);
        return s == 0 ? enc_bit_clk_tick : (s == 1 ? dec_bit_clk_tick : sc_filter_tick);
    endfunction

    // Spacing between the second and third tick seen
    task automatic period(input int s, input logic [11:0] exp);
        int k;
        int t [3];
        k = 0;
        for (int c = 0; c < 1000 && k < 3; c++) begin
            settle();
            if (tick(s) === 1'b1) begin
                t[k] = c;
                k++;
            end
        end
        check(16'((k == 3) ? t[2] - t[1] : 0), {4'h0, exp});
    endtask

    // Ticks of one source over a window that holds whole periods
    task automatic count(input int s, input int n, input logic [3:0] exp);
        int k;
        k = 0;
        repeat (40) settle();
        for (int c = 0; c < n; c++) begin
            settle();
            if (tick(s) === 1'b1) begin
                k++;
            end
        end
        check(16'(k), {12'h0, exp});
    endtask

    // Decode tick spacing with one phase step pulsed just after a tick
    task automatic pll_step(input logic adv, input logic [11:0] exp);
        int c;
        c = 0;
        do begin
            settle();
            c++;
        end while (c < 300 && dec_bit_clk_tick !== 1'b1);
        @(posedge ref_clk);
        pll_phase_advance <= adv;
        pll_phase_retard <= !adv;
        @(posedge ref_clk);
        pll_phase_advance <= 1'b0;
        pll_phase_retard <= 1'b0;
        c = 2;
        do begin
            settle();
            c++;
        end while (c < 300 && dec_bit_clk_tick !== 1'b1);
        check(16'(c), {4'h0, exp});
    endtask

    // ****************
    // Clock and sequence
    // ****************
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        miscompares++;
        finish_test();
    end

    initial begin
        {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 26'h0};
        {pll_enable, pll_phase_advance, pll_phase_retard} = 3'h0;
        {tx_bit_in, tx_bit_valid, rx_bit_in, rx_bit_valid} = 4'h0;
        {ts, rs} = 20'h0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            wr(rows[i][39:32], rows[i][31:16]);
            rd(rows[i][39:32], d);
            check(d, rows[i][15:0]);
        end
        for (int i = 0; i < 8; i++) begin
            wr(CCR_ADDR_MODE, 16'(i));
            settle();
            check({13'h0, codec_mode}, 16'(i));
            check({codec_buffered_io, codec_pcm}, {i >= 1 && i <= 4, i >= 2 && i <= 4});
        end
        wr(CCR_ADDR_POWER1, 16'h0041);
        for (int i = 0; i < 4; i++) begin
            wr(CCR_ADDR_POWER2, 16'(i * 4 + 1));
            settle();
            check({2'h0, power}, {6'h0, 2'(i), 8'h41});
            check({osc_power_down, bandgap_enable}, 16'h0001);
        end
        wr(CCR_ADDR_POWER2, 16'h00fe);
        settle();
        check({2'h0, power}, 16'h0000);
        check({osc_power_down, bandgap_enable}, 16'h0002);
        for (int i = 0; i < 8; i++) begin
            wr(CCR_ADDR_CLKDIV, crow[i][51:36]);
            period(0, crow[i][35:24]);
            period(1, crow[i][23:12]);
            period(2, crow[i][11:0]);
        end
        // Phase steps act on the decode clock only with the loop enabled
        pll_step(1'b1, 12'd64);
        @(posedge ref_clk);
        pll_enable <= 1'b1;
        pll_step(1'b1, 12'd62);
        pll_step(1'b0, 12'd66);
        @(posedge ref_clk);
        pll_enable <= 1'b0;
        // Fractional filter ratios; the last row lands nearest to 256 kHz
        for (int i = 0; i < 4; i++) begin
            wr(CCR_ADDR_CLKDIV, frow[i][31:16]);
            count(2, frow[i][15:4], frow[i][3:0]);
        end
        // Reset in mid-run clears every register and the power, mode and power flag outputs
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(addrs[i], d);
            check(d, 16'h0000);
            @(posedge ref_clk);
        end
        check({2'h0, power}, 16'h0000);
        check({11'h0, codec_mode, osc_power_down, bandgap_enable}, 16'h0000);
        // Scrambler and de-scrambler, back to back bits
        for (int j = 0; j < 2; j++) begin
            cfg = j ? 16'hb605 : 16'h0000;
            wr(CCR_ADDR_SCRAM, cfg);
            for (int i = 0; i < 17; i++) begin
                @(posedge ref_clk);
                tx_bit_valid <= i < 16;
                rx_bit_valid <= i < 16;
                tx_bit_in <= pat[i % 16];
                rx_bit_in <= ~pat[i % 16];
                #1;
                if (i > 0) begin
                    check({tx_bit_out_valid, rx_bit_out_valid, tx_bit_out, rx_bit_out},
                        {14'h3, eo, ro});
                end
                if (i < 16) begin
                    m = pat[i] ^ (cfg[15] & ^(cfg[9:0] & ts));
                    eo = m ^ cfg[13];
                    ts = {ts[8:0], m};
                    l = ~pat[i] ^ cfg[10];
                    ro = l ^ (cfg[12] & ^(cfg[9:0] & rs));
                    rs = {rs[8:0], l};
                end
            end
        end
        finish_test();
    end
endmodule
